// *** dca_arb_if.sv ***
// Signals between the transfer controller and the channel arbiter
`timescale 1ns/10ps
`default_nettype none
interface dca_arb_if;
  logic [3:0] req;
  logic [1:0] mode;
  logic       rotate;
  logic [1:0] done_ch;
  logic       gnt_vld;
  logic [1:0] gnt_ch;
  modport ctl (output req, mode, rotate, done_ch, input gnt_vld, gnt_ch);
  modport arb (input req, mode, rotate, done_ch, output gnt_vld, gnt_ch);
endinterface
`default_nettype wire

// *** dca_arbiter.sv ***
// Channel priority arbiter with fixed and rotating orders
`timescale 1ns/10ps
`default_nettype none
module dca_arbiter
  import dca_pkg::*;
(
  input  wire logic clock_i,  // Bus clock
  input  wire logic reset_i,  // Async reset, high
  dca_arb_if.arb    ab        // Arbitration requests and grant
);
  logic [1:0] ord_r   [4];
  logic [1:0] ord_nxt [4];
  logic [1:0] list    [4];
  logic [1:0] pos;

  // ==========================================================================
  // Active order, highest first
  always_comb begin
    if (ab.mode == DCA_PRI_FIXB) begin
      list = '{2'h0, 2'h2, 2'h3, 2'h1};
    end else if (ab.mode == DCA_PRI_RR) begin
      list = ord_r;
    end else begin
      list = '{2'h0, 2'h1, 2'h2, 2'h3};
    end
  end

  // One grant, first requester in the active order
  always_comb begin
    ab.gnt_vld = 1'b0;
    ab.gnt_ch  = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (ab.req[list[i]]) begin
        ab.gnt_vld = 1'b1;
        ab.gnt_ch  = list[i];
      end
    end
  end

  // ==========================================================================
  // Rotation: finished channel to the bottom, those below move up
  always_comb begin
    pos = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (ord_r[i] == ab.done_ch) begin
        pos = 2'(i);
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_rot
    if (g == 3) begin : g_last
      assign ord_nxt[g] = ab.done_ch;
    end else begin : g_mid
      assign ord_nxt[g] = (2'(g) >= pos) ? ord_r[g+1] : ord_r[g];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ord_r <= '{2'h0, 2'h1, 2'h2, 2'h3};
    end else if (ab.rotate && ab.mode == DCA_PRI_RR) begin
      ord_r <= ord_nxt;
    end
  end

  AST_ONE_GRANT: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (ab.req != 4'h0) |-> ab.gnt_vld && ab.req[ab.gnt_ch])
    else $error("No single valid grant for pending requests");

  AST_FIXB_ORDER: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (ab.mode == DCA_PRI_FIXB) && !ab.req[0] && ab.req[2] |-> ab.gnt_ch == 2'h2)
    else $error("Second fixed order not honoured");

  AST_RR_BOTTOM: assert property (
    @(posedge clock_i) disable iff (reset_i)
    ab.rotate && (ab.mode == DCA_PRI_RR) |=> ord_r[3] == $past(ab.done_ch))
    else $error("Finished channel not moved to lowest priority");

endmodule
`default_nettype wire

// *** dca_bus_model.sv ***
// Bus owner, memory and acknowledge device model facing the DMA core
`timescale 1ns/10ps
`default_nettype none
module dca_bus_model (
  input  wire logic        clock_i,   // Bus clock
  input  wire logic        reset_i,   // Async reset, high
  input  wire logic        bus_req_i, // Ownership request
  input  wire logic        rd_i,      // Read cycle active
  input  wire logic        wr_i,      // Write cycle active
  input  wire logic [1:0]  wait_i,    // Wait states per cycle
  output logic             grant_o,   // Bus granted
  output logic             done_o,    // Cycle ends
  output logic      [31:0] rdata_o    // Read data
);
  logic [1:0]  cnt_r;
  logic [31:0] word_r;
  logic        busy;
  assign busy = (rd_i || wr_i) && !done_o;
  // Data only in the ending read cycle; a changing pattern elsewhere
  assign rdata_o = (rd_i && done_o) ? word_r : ~word_r ^ {30'h0, cnt_r};
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      grant_o <= 1'b0;
      done_o  <= 1'b0;
      cnt_r   <= 2'h0;
      word_r  <= 32'hA5000001;
    end else begin
      grant_o <= bus_req_i;
      done_o  <= busy && cnt_r == wait_i;
      cnt_r   <= (busy && cnt_r != wait_i) ? cnt_r + 2'h1 : 2'h0;
      if (rd_i && done_o)
        word_r <= {word_r[30:0], word_r[31]} + 32'h1;
    end
  end
endmodule
`default_nettype wire

// *** dca_core.sv ***
// Four-channel DMA arbitration, address mode and bus mode controller
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Simultaneous requests grant exactly one channel.
// - Two fixed orders plus round-robin selectable.
// - Round-robin: finished channel drops to bottom.
// - Round-robin order resets to 0,1,2,3.
// - Late requests wait for updated order.
// - No ack-device to peripheral transfers.
// - Single mode: ack device, memory, pin request.
// - 16-byte peripheral units need longword access.
// - Dual mode: read source, then write destination.
// - Dual mode ack in read or write cycle.
// - Dual mode accepts auto, pin, peripheral requests.
// - Single mode: one cycle, ack plus address.
// - Per-channel cycle-steal or burst selection.
// - Cycle-steal normal releases bus after each unit.
// - Intermittent waits 16 or 64 clocks first.
// - Regained bus waits out cache line refill.
// - Only enabled, unflagged channels join arbitration.
// - Burst keeps transferring until end condition.
module dca_core
  import dca_pkg::*;
(
  input  wire logic        clock_i,               // Bus clock
  input  wire logic        reset_i,               // Async reset, high
  input  wire logic [7:0]  reg_addr_i,            // Register byte address
  input  wire logic [31:0] reg_wdata_i,           // Register write data
  input  wire logic        reg_wr_i,              // Register write strobe
  input  wire logic        reg_rd_i,              // Register read strobe
  output logic      [31:0] reg_rdata_o,           // Read data, next cycle
  input  wire logic [1:0]  transfer_request_in_i, // Request pins, ch 0 and 1
  input  wire logic        nmi_i,                 // Nonmaskable interrupt pin
  input  wire logic [3:0]  periph_req_i,          // On-chip peripheral requests
  input  wire logic [3:0]  periph_lw_ok_i,        // Peripheral takes longwords
  input  wire logic [3:0]  chan_end_i,            // Channel end condition pulse
  input  wire logic        addr_err_i,            // Address error pulse
  input  wire logic        bus_grant_i,           // Bus granted to this master
  input  wire logic        cache_refill_i,        // Cache line refill busy
  input  wire logic        cycle_done_i,          // Current bus cycle ends
  input  wire logic [31:0] bus_rdata_i,           // Bus read data
  output logic             bus_req_o,             // Bus ownership request
  output logic             bus_rd_o,              // Read cycle active
  output logic             bus_wr_o,              // Write cycle active
  output logic             bus_single_o,          // Single address cycle
  output logic      [1:0]  bus_ch_o,              // Channel on the bus
  output logic      [1:0]  bus_size_o,            // Transfer unit size
  output logic      [31:0] bus_wdata_o,           // Held data for write cycle
  output logic      [1:0]  transfer_ack_out_o,    // Acknowledge, ch 0 and 1
  output logic             unit_done_o            // One unit completed
);

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {nmi_i, transfer_request_in_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================================
  // Declarations
  logic [OPER_W-1:0] oper_r;
  logic [CHAN_W-1:0] chan_r [4];
  dca_state_t        state_r;
  dca_state_t        state_nxt;
  logic [1:0]        sel_r;
  logic [1:0]        sel_nxt;
  logic [6:0]        gap_cnt_r;
  logic [6:0]        gap_len;
  logic [6:0]        rel_cnt_r;
  logic [31:0]       hold_r;
  logic [31:0]       rd_mux;
  logic [3:0]        req_e;
  logic [3:0]        tb_c;
  logic [3:0]        akw_c;
  logic [3:0]        akd_c;
  logic [3:0]        sgl_c;
  logic [3:0]        pin_c;
  logic [1:0]        ts_c [4];
  logic [1:0]        im;
  logic              flags_ok;
  logic              gap_on;
  logic              keep_bus;
  logic              ch_hit;
  logic              sgl_n;
  logic              akw_n;
  logic              akd_n;
  logic              mem_rd_n;
  dca_state_t        start_st;
  dca_state_t        rel_st;

  assign ch_hit   = (reg_addr_i[7:4] == DCA_OFS_CHAN[7:4]) && (reg_addr_i[1:0] == 2'h0);
  assign flags_ok = oper_r[OP_ME] & ~oper_r[OP_AE] & ~oper_r[OP_NMI];
  assign im       = oper_r[OP_IM+1:OP_IM];
  assign gap_on   = (im != DCA_IM_NORM);
  assign gap_len  = (im == DCA_IM_64) ? DCA_GAP64_CYC : DCA_GAP16_CYC;

  // ==========================================================================
  // Operation register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      oper_r <= DCA_OPER_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == DCA_OFS_OPER) begin
        oper_r <= reg_wdata_i[OPER_W-1:0];
      end
      // Hardware set wins over a clearing write
      if (pin_sync_r[2]) begin
        oper_r[OP_NMI] <= 1'b1;
      end
      if (addr_err_i) begin
        oper_r[OP_AE] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Channel control and request qualification
  for (genvar g = 0; g < 4; g++) begin : g_chan
    logic [CHAN_W-1:0] cfg_r;
    logic [1:0]        rs;
    logic              pin_req;
    logic              src;
    logic              bad;

    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        cfg_r <= DCA_CHAN_RST;
      end else begin
        if (reg_wr_i && ch_hit && reg_addr_i[3:2] == 2'(g)) begin
          cfg_r <= reg_wdata_i[CHAN_W-1:0];
        end
        if (chan_end_i[g]) begin
          cfg_r[CH_TE] <= 1'b1;
        end
      end
    end

    assign rs = cfg_r[CH_RS+1:CH_RS];
    if (g < 2) begin : g_pin
      assign pin_req = pin_sync_r[g];
    end else begin : g_nopin
      assign pin_req = 1'b0;
    end

    always_comb begin
      unique case (rs)
        DCA_RS_AUTO: src = 1'b1;
        DCA_RS_PIN:  src = pin_req;
        DCA_RS_PERI: src = periph_req_i[g];
        default:     src = 1'b0;
      endcase
    end

    assign bad = (cfg_r[CH_SGL] & ((rs != DCA_RS_PIN) | cfg_r[CH_PER]))
               | (cfg_r[CH_AKD] & cfg_r[CH_PER])
               | ((cfg_r[CH_TS+1:CH_TS] == DCA_TS_16B) & cfg_r[CH_PER]
                  & ~periph_lw_ok_i[g]);

    assign req_e[g]  = cfg_r[CH_EN] & ~cfg_r[CH_TE] & flags_ok & ~bad & src;
    assign chan_r[g] = cfg_r;
    assign tb_c[g]   = cfg_r[CH_TB];
    assign akw_c[g]  = cfg_r[CH_AKW];
    assign akd_c[g]  = cfg_r[CH_AKD];
    assign sgl_c[g]  = cfg_r[CH_SGL];
    assign pin_c[g]  = (rs == DCA_RS_PIN) & (g < 2);
    assign ts_c[g]   = cfg_r[CH_TS+1:CH_TS];
  end

  // ==========================================================================
  // Arbiter
  dca_arb_if arb_bus ();

  assign arb_bus.req     = req_e;
  assign arb_bus.mode    = {oper_r[OP_PR_HI], oper_r[OP_PR_LO]};
  assign arb_bus.rotate  = (state_r == DCA_ST_WR) && cycle_done_i;
  assign arb_bus.done_ch = sel_r;

  dca_arbiter u_arb (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .ab      (arb_bus)
  );

  // ==========================================================================
  // Transfer sequencing
  // Rotation lands as the last cycle ends, so the boundary decision sees the new order
  assign keep_bus = arb_bus.gnt_vld
                  & (tb_c[arb_bus.gnt_ch] | (tb_c[sel_r] & req_e[sel_r]));
  assign start_st = sgl_c[arb_bus.gnt_ch] ? DCA_ST_WR : DCA_ST_RD;
  assign rel_st   = gap_on ? DCA_ST_GAP : DCA_ST_IDLE;

  always_comb begin
    state_nxt = state_r;
    sel_nxt   = sel_r;
    unique case (state_r)
      DCA_ST_IDLE: begin
        if (|req_e) begin
          state_nxt = DCA_ST_ACQ;
        end
      end
      DCA_ST_ACQ: begin
        if (bus_grant_i && !cache_refill_i) begin
          if (arb_bus.gnt_vld) begin
            sel_nxt   = arb_bus.gnt_ch;
            state_nxt = start_st;
          end else begin
            state_nxt = rel_st;
          end
        end
      end
      DCA_ST_RD: begin
        if (cycle_done_i) begin
          state_nxt = DCA_ST_WR;
        end
      end
      DCA_ST_WR: begin
        if (cycle_done_i) begin
          state_nxt = DCA_ST_DONE;
        end
      end
      DCA_ST_DONE: begin
        if (keep_bus) begin
          sel_nxt   = arb_bus.gnt_ch;
          state_nxt = start_st;
        end else begin
          state_nxt = rel_st;
        end
      end
      DCA_ST_GAP: begin
        if (gap_cnt_r == gap_len - 7'h01) begin
          state_nxt = DCA_ST_IDLE;
        end
      end
      default: state_nxt = DCA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= DCA_ST_IDLE;
      sel_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      sel_r   <= sel_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt_r <= 7'h00;
    end else if (state_r == DCA_ST_GAP) begin
      gap_cnt_r <= gap_cnt_r + 7'h01;
    end else begin
      gap_cnt_r <= 7'h00;
    end
  end

  // Source data held between the read and the write cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      hold_r <= 32'h0;
    end else if (state_r == DCA_ST_RD && cycle_done_i) begin
      hold_r <= bus_rdata_i;
    end
  end
  assign bus_wdata_o = hold_r;

  // ==========================================================================
  // Bus outputs
  assign sgl_n    = sgl_c[sel_nxt];
  assign akw_n    = akw_c[sel_nxt];
  assign akd_n    = akd_c[sel_nxt];
  assign mem_rd_n = sgl_n & ~akw_n;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bus_req_o          <= 1'b0;
      bus_rd_o           <= 1'b0;
      bus_wr_o           <= 1'b0;
      bus_single_o       <= 1'b0;
      bus_ch_o           <= 2'h0;
      bus_size_o         <= 2'h0;
      transfer_ack_out_o <= 2'h0;
      unit_done_o        <= 1'b0;
    end else begin
      bus_req_o    <= state_nxt inside {DCA_ST_ACQ, DCA_ST_RD, DCA_ST_WR, DCA_ST_DONE};
      bus_rd_o     <= (state_nxt == DCA_ST_RD) | ((state_nxt == DCA_ST_WR) & mem_rd_n);
      bus_wr_o     <= (state_nxt == DCA_ST_WR) & ~mem_rd_n;
      bus_single_o <= sgl_n;
      bus_ch_o     <= sel_nxt;
      bus_size_o   <= ts_c[sel_nxt];
      unit_done_o  <= (state_r == DCA_ST_WR) & cycle_done_i;
      for (int c = 0; c < 2; c++) begin
        transfer_ack_out_o[c] <= (sel_nxt == 2'(c))
          & (((state_nxt == DCA_ST_WR) & sgl_n)
             | (akd_n & (state_nxt == DCA_ST_WR) & akw_n)
             | (akd_n & (state_nxt == DCA_ST_RD) & ~akw_n));
      end
    end
  end

  // ==========================================================================
  // Register read port
  always_comb begin
    if (reg_addr_i == DCA_OFS_OPER) begin
      rd_mux = 32'(oper_r);
    end else if (reg_addr_i == DCA_OFS_STAT) begin
      rd_mux = 32'({req_e, sel_r, state_r, bus_req_o});
    end else if (ch_hit) begin
      rd_mux = 32'(chan_r[reg_addr_i[3:2]]);
    end else begin
      rd_mux = 32'h0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rel_cnt_r <= 7'h7F;
    end else if (!gap_on) begin
      // A release outside intermittent mode owes no wait
      rel_cnt_r <= 7'h7F;
    end else if (bus_req_o) begin
      rel_cnt_r <= 7'h00;
    end else if (rel_cnt_r != 7'h7F) begin
      rel_cnt_r <= rel_cnt_r + 7'h01;
    end
  end

  AST_ELIG: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (state_r == DCA_ST_ACQ) && (state_nxt inside {DCA_ST_RD, DCA_ST_WR}) |-> req_e[sel_nxt])
    else $error("Started a unit on an ineligible channel");

  AST_CACHE: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (state_r == DCA_ST_ACQ) && cache_refill_i |=> (state_r == DCA_ST_ACQ) && !bus_rd_o && !bus_wr_o)
    else $error("Transfer started during cache refill");

  AST_DUAL: assert property (
    @(posedge clock_i) disable iff (reset_i)
    $rose(bus_wr_o) && !bus_single_o |-> $past(bus_rd_o) && $past(state_r) == DCA_ST_RD)
    else $error("Dual write cycle not preceded by read cycle");

  AST_ACK: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (transfer_ack_out_o != 2'h0) && !bus_single_o |-> (bus_wr_o == akw_c[bus_ch_o]))
    else $error("Acknowledge in the wrong dual cycle");

  AST_SGL: assert property (
    @(posedge clock_i) disable iff (reset_i)
    bus_single_o && (bus_rd_o || bus_wr_o) |-> pin_c[bus_ch_o] && !bus_ch_o[1])
    else $error("Single address cycle without pin request");

  AST_ONECYC: assert property (
    @(posedge clock_i) disable iff (reset_i)
    bus_single_o && (bus_rd_o || bus_wr_o) |-> transfer_ack_out_o[bus_ch_o[0]] && (state_r == DCA_ST_WR))
    else $error("Single cycle lacks acknowledge or used two cycles");

  AST_CS: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (state_r == DCA_ST_DONE) && !keep_bus |=> !bus_req_o)
    else $error("Bus not released after cycle-steal unit");

  AST_BURST: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (state_r == DCA_ST_DONE) && arb_bus.gnt_vld && tb_c[arb_bus.gnt_ch]
      |=> bus_req_o && (bus_rd_o || bus_wr_o))
    else $error("Burst channel did not continue");

  AST_GAP: assert property (
    @(posedge clock_i) disable iff (reset_i)
    $rose(bus_req_o) && gap_on |-> rel_cnt_r >= gap_len)
    else $error("Bus reacquired before intermittent wait");

  AST_BOUND: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (state_r inside {DCA_ST_RD, DCA_ST_WR}) |-> (sel_nxt == sel_r))
    else $error("Channel changed inside a unit");

endmodule
`default_nettype wire

// *** dca_core_test.sv ***
// Self-checking bench for the DMA arbitration and bus mode core
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module dca_core_test
  import dca_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, nmi = 1'b0, refl = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, brd, bwd;
  logic [1:0]  pin = 2'h0, wt = 2'h1, bch, bsz, ack, ackv = 2'h0, u_ack;
  logic [3:0]  preq = 4'h0, lwok = 4'h0;
  logic        gnt, cdone, breq, b_rd, b_wr, sgl, udone, low = 1'b1, u_low;
  logic [1:0]  u_ch;
  int          failures = 0, n_compared = 0, i, j, k, lo, uk = 0, taken = 0, hq, hc;
  int          ncyc = 0, gap = 0, u_cyc, u_gap;
  always #5 clk = ~clk;
  dca_core dut (.clock_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .transfer_request_in_i(pin),
    .nmi_i(nmi), .periph_req_i(preq), .periph_lw_ok_i(lwok), .chan_end_i(4'h0),
    .addr_err_i(1'b0), .bus_grant_i(gnt), .cache_refill_i(refl), .cycle_done_i(cdone),
    .bus_rdata_i(brd), .bus_req_o(breq), .bus_rd_o(b_rd), .bus_wr_o(b_wr),
    .bus_single_o(sgl), .bus_ch_o(bch), .bus_size_o(bsz), .bus_wdata_o(bwd),
    .transfer_ack_out_o(ack), .unit_done_o(udone));
  dca_bus_model bus (.clock_i(clk), .reset_i(rst), .bus_req_i(breq), .rd_i(b_rd),
    .wr_i(b_wr), .wait_i(wt), .grant_o(gnt), .done_o(cdone), .rdata_o(brd));
  // ==========================================================================
  // Unit monitor: records channel, cycles, acknowledge and release per unit
  logic [31:0] rsave = 32'h0;
  always @(posedge clk) begin
    gap++;
    if (!breq) low = 1'b1;
    if (ack[0]) ackv = ackv | {b_wr, b_rd};
    if (b_wr && !sgl && cdone) `CHK("wdata", rsave, bwd)
    if ((b_rd || b_wr) && cdone) ncyc++;
    if (b_rd && cdone) rsave = brd;
    if (udone) begin
      u_ch = bch; u_cyc = ncyc; u_ack = ackv; u_low = low; u_gap = gap; uk++;
      ncyc = 0; ackv = 2'h0; low = 1'b0; gap = 0;
    end
  end
  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    `CHK("rdata", e, rdat)
  endtask
  function automatic logic [31:0] op(input logic [1:0] pr, input logic [1:0] im);
    return (32'h1 << OP_ME) | (32'(pr[0]) << OP_PR_LO) | (32'(pr[1]) << OP_PR_HI)
      | (32'(im) << OP_IM);
  endfunction
  function automatic logic [31:0] cfg(input logic [1:0] rs, input logic [31:0] x);
    return (32'h1 << CH_EN) | (32'(rs) << CH_RS) | x;
  endfunction
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic get_unit;
    int n;
    for (n = 0; n < 500 && uk == taken; n++) @(posedge clk);
    if (uk == taken) begin
      `CHK("unit_wait", 1, 0)
      summarize();
    end
    taken = uk;
  endtask
  task automatic stop;
    int n;
    wr(DCA_OFS_OPER, 32'h0);
    for (n = 0; n < 200 && (breq !== 1'b0 || b_rd || b_wr); n++) @(posedge clk);
    `CHK("stopped", 3'b000, {breq, b_rd, b_wr})
    repeat (3) @(posedge clk);
    taken = uk;
  endtask
  task automatic idle(input int n);
    hq = 0;
    hc = 0;
    repeat (n) begin
      @(posedge clk);
      hq += breq;
      hc += (b_rd | b_wr);
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(DCA_OFS_OPER, 32'h0);
    rd(DCA_OFS_CHAN, 32'h0);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'h0);
    $display("test reset done");
    for (i = 0; i < 4; i++) wr(DCA_OFS_CHAN + 8'(4 * i), i == 2 ? 0 : cfg(DCA_RS_PERI, 0));
    preq <= 4'b1001;
    wr(DCA_OFS_OPER, op(DCA_PRI_RR, 2'h0));
    for (k = 0; k < 200 && b_rd !== 1'b1; k++) @(posedge clk);
    `CHK("rr_start", 1'b1, b_rd)
    preq <= 4'b1011;
    for (i = 0; i < 6; i++) begin
      get_unit();
      `CHK("rr_ch", 12'h1C7 >> (10 - 2 * i) & 3, u_ch)
      `CHK("dual_cycles", 2, u_cyc)
      `CHK("released", 1'b1, u_low)
    end
    stop();
    $display("test round robin done");
    for (i = 0; i < 4; i++) wr(DCA_OFS_CHAN + 8'(4 * i), cfg(DCA_RS_PERI, 0));
    for (j = 0; j < 4; j++) begin
      preq <= 4'(16'hEEAC >> (12 - 4 * j));
      wr(DCA_OFS_OPER, op(2'(8'h17 >> (6 - 2 * j)), 2'h0));
      for (i = 0; i < 2; i++) begin
        get_unit();
        `CHK("fixed_ch", 2'(8'h6E >> (6 - 2 * j)), u_ch)
      end
      stop();
    end
    $display("test fixed done");
    preq <= 4'h0;
    for (i = 1; i < 4; i++) wr(DCA_OFS_CHAN + 8'(4 * i), 32'h0);
    wr(DCA_OFS_CHAN, cfg(DCA_RS_AUTO, 0));
    for (j = 0; j < 4; j++) begin
      lo = (j == 2) ? 64 : (j == 0 ? 0 : 16);
      wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'(j)));
      repeat (3) get_unit();
      `CHK("gap", 1'b1, u_gap > lo && u_gap < lo + 25)
      stop();
    end
    refl <= 1'b1;
    wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'h0));
    idle(30);
    `CHK("postponed", 0, hc)
    refl <= 1'b0;
    get_unit();
    stop();
    $display("test intermittent done");
    wt <= 2'h0;
    wr(DCA_OFS_CHAN, cfg(DCA_RS_AUTO, 32'h1 << CH_TB));
    wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'h0));
    repeat (3) get_unit();
    `CHK("burst_held", 1'b0, u_low)
    stop();
    pin <= 2'b01;
    for (j = 0; j < 4; j++) begin
      wr(DCA_OFS_CHAN, cfg(DCA_RS_PIN, (32'h1 << (j < 2 ? CH_SGL : CH_AKD))
        | (32'(j & 1) << CH_AKW)));
      wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'h0));
      get_unit();
      `CHK("ack_cycle", (j & 1) ? 2'b10 : 2'b01, u_ack)
      `CHK("cycles", j < 2 ? 1 : 2, u_cyc)
      stop();
    end
    $display("test burst and ack done");
    pin <= 2'b00;
    preq <= 4'b0001;
    for (j = 0; j < 4; j++) begin
      lwok <= {3'b000, j == 2};
      wr(DCA_OFS_CHAN, j == 0 ? cfg(DCA_RS_AUTO, 32'h1 << CH_SGL)
        : j == 3 ? cfg(DCA_RS_PERI, (32'h1 << CH_AKD) | (32'h1 << CH_PER))
        : cfg(DCA_RS_PERI, (32'h1 << CH_PER) | (32'(DCA_TS_16B) << CH_TS)));
      wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'h0));
      idle(40);
      `CHK("requested", j == 2, hq != 0)
      if (j == 2) `CHK("unit_size", DCA_TS_16B, bsz)
      stop();
    end
    nmi <= 1'b1;
    wr(DCA_OFS_CHAN, cfg(DCA_RS_AUTO, 0));
    wr(DCA_OFS_OPER, op(DCA_PRI_FIXA, 2'h0));
    idle(40);
    `CHK("nmi_refused", 0, hq)
    rd(DCA_OFS_OPER, (32'h1 << OP_ME) | (32'h1 << OP_NMI));
    $display("test refusals done");
    summarize();
  end
endmodule
`default_nettype wire

// *** dca_pkg.sv ***
// Constants and types shared by the DMA channel arbitration core
package dca_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  DCA_OFS_OPER = 8'h00;
  localparam logic [7:0]  DCA_OFS_STAT = 8'h08;
  localparam logic [7:0]  DCA_OFS_CHAN = 8'h10;

  // ==========================================================================
  // Operation register fields
  localparam int          OPER_W       = 7;
  localparam int          OP_ME        = 0;
  localparam int          OP_NMI       = 1;
  localparam int          OP_AE        = 2;
  localparam int          OP_PR_LO     = 3;
  localparam int          OP_PR_HI     = 4;
  localparam int          OP_IM        = 5;
  localparam logic [6:0]  DCA_OPER_RST = 7'h00;

  // ==========================================================================
  // Channel control register fields
  localparam int          CHAN_W       = 11;
  localparam int          CH_EN        = 0;
  localparam int          CH_TE        = 1;
  localparam int          CH_TB        = 2;
  localparam int          CH_AKW       = 3;
  localparam int          CH_SGL       = 4;
  localparam int          CH_RS        = 5;
  localparam int          CH_TS        = 7;
  localparam int          CH_PER       = 9;
  localparam int          CH_AKD       = 10;
  localparam logic [10:0] DCA_CHAN_RST = 11'h000;

  // ==========================================================================
  // Encodings and counts
  localparam logic [1:0]  DCA_PRI_FIXA = 2'h0;
  localparam logic [1:0]  DCA_PRI_FIXB = 2'h1;
  localparam logic [1:0]  DCA_PRI_RR   = 2'h2;
  localparam logic [1:0]  DCA_RS_AUTO  = 2'h0;
  localparam logic [1:0]  DCA_RS_PIN   = 2'h1;
  localparam logic [1:0]  DCA_RS_PERI  = 2'h2;
  localparam logic [1:0]  DCA_TS_16B   = 2'h3;
  localparam logic [1:0]  DCA_IM_NORM  = 2'h0;
  localparam logic [1:0]  DCA_IM_64    = 2'h2;
  localparam logic [6:0]  DCA_GAP16_CYC = 7'h10;
  localparam logic [6:0]  DCA_GAP64_CYC = 7'h40;

  typedef enum logic [2:0] {
    DCA_ST_IDLE = 3'h0,
    DCA_ST_ACQ  = 3'h1,
    DCA_ST_RD   = 3'h3,
    DCA_ST_WR   = 3'h2,
    DCA_ST_DONE = 3'h6,
    DCA_ST_GAP  = 3'h7
  } dca_state_t;

endpackage
